/* sdl_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - take one serial frame, drive four lanes plus clock
// - lock with no reference and no training
// - check clock bits, validate, then unpack
// - undo dc balance of frames, scrambling of normal frames
// - low-frequency select picks pixel clock range
// - back channel sends i2c, crc, four gpio
// - forward embedded control, slow reverse signalling
// - bridge i2c transactions across the link
// - bridged i2c allows multi-master arbitration
// - local host reaches device or remote serializer
// - backward mode receives shorter legacy frames
// - backward mode from pin or control bit
// - backward mode disables control, gpio, audio, interrupt
// - backward mode keeps local i2c to serializer
// - lock output high only after lock completes
module sdl_core import sdl_pkg::*; (
  // clocks and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic link_clk_i,
  // serial link and straps
  input wire logic rx_bit_i,
  input wire logic power_down_n_i,
  input wire logic low_freq_select_i,
  input wire logic bkwd_pin_i,
  input wire logic bkwd_ctrl_i,
  input wire logic [3:0] gpio_i,
  // local i2c bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // lvds lanes
  output logic [LANES-1:0] lane_o,
  output logic lane_clk_o,
  // status, audio, back channel
  output logic lock_o,
  output logic i2s_data_o,
  output logic interrupt_out_n_o,
  output logic bc_tx_o
);
  // ==================================================
  // pin synchronisers and reset
  logic [8:0] pin_s;
  logic pdn_s, lf_s, bkp_s, scl_s, sda_s;
  logic [3:0] gpio_s;
  logic rstn_r, rstn_nxt, lf_r, lf_nxt, bk_r, bk_nxt;

  sdl_sync #(.W(9)) u_pin_sync (
    .clk_i(mclk_i),
    .d_i({power_down_n_i, low_freq_select_i, bkwd_pin_i, gpio_i, scl_i, sda_i}),
    .q_o(pin_s)
  );
  assign {pdn_s, lf_s, bkp_s, gpio_s, scl_s, sda_s} = pin_s;

  // power-down acts as reset; low-frequency strap freezes at release
  always_comb begin
    rstn_nxt = resetn_i & pdn_s;
    lf_nxt = rstn_r ? lf_r : lf_s;
    bk_nxt = bkp_s | bkwd_ctrl_i;
  end

  always_ff @(posedge mclk_i) begin
    rstn_r <= rstn_nxt;
    lf_r <= lf_nxt;
    if (!rstn_r) begin
      bk_r <= 1'b0;
    end else begin
      bk_r <= bk_nxt;
    end
  end

  // ==================================================
  // link clock domain
  logic [2:0] to_link_s;
  logic [PAY_W-1:0] word_l;
  logic tog_l, lock_l;

  // reset and modes cross as levels
  sdl_sync #(.W(3)) u_to_link (
    .clk_i(link_clk_i),
    .d_i({rstn_r, bk_r, lf_r}),
    .q_o(to_link_s)
  );

  sdl_link_rx u_rx (
    .link_clk_i(link_clk_i),
    .lrst_n_i(to_link_s[2]),
    .rx_bit_i(rx_bit_i),
    .bkwd_i(to_link_s[1]),
    .lf_i(to_link_s[0]),
    .word_o(word_l),
    .tog_o(tog_l),
    .lock_o(lock_l)
  );

  // ==================================================
  // word crossing: toggle, then capture of held word
  logic [1:0] back_s;
  logic tog_s, lck_s;

  sdl_sync #(.W(2)) u_to_mclk (
    .clk_i(mclk_i),
    .d_i({tog_l, lock_l}),
    .q_o(back_s)
  );
  assign {tog_s, lck_s} = back_s;

  logic tgd_r, tgd_nxt, newf, vld_r, vld_nxt;
  logic [PAY_W-1:0] pix_r, pix_nxt;

  always_comb begin
    newf = tog_s ^ tgd_r;
    tgd_nxt = tog_s;
    pix_nxt = newf ? word_l : pix_r;
    // valid once locked and a frame has landed
    vld_nxt = lck_s & (vld_r | newf);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_r) begin
      tgd_r <= 1'b0;
      pix_r <= '0;
      vld_r <= 1'b0;
    end else begin
      tgd_r <= tgd_nxt;
      pix_r <= pix_nxt;
      vld_r <= vld_nxt;
    end
  end

  // ==================================================
  // unpack payload per mode
  logic [23:0] rgb;
  logic hs, vs, de, r_sda, r_scl, aud, r_int_n;
  logic [LANES*SLOTS-1:0] lword;

  // unpack the word being captured, so the lanes load the newest pixel
  always_comb begin
    if (bk_r) begin
      rgb = {2'h0, pix_nxt[P_RGB +: BK_RGB_W]};
      hs = pix_nxt[BK_HS];
      vs = pix_nxt[BK_VS];
      de = pix_nxt[BK_DE];
    end else begin
      rgb = pix_nxt[P_RGB +: 24];
      hs = pix_nxt[P_HS];
      vs = pix_nxt[P_VS];
      de = pix_nxt[P_DE];
    end
    // control channel fields exist only in normal frames
    r_sda = bk_r | pix_nxt[P_SDA];
    r_scl = bk_r | pix_nxt[P_SCL];
    aud = ~bk_r & pix_nxt[P_AUD];
    r_int_n = bk_r | pix_nxt[P_INT];
    lword = {1'b0, de, vs, hs, rgb};
  end

  // ==================================================
  // lvds serialiser: seven slots per pixel
  logic [2:0] slot_r, slot_nxt;
  logic [LANES*SLOTS-1:0] lw_r, lw_nxt;
  logic [LANES-1:0] lane_r, lane_nxt;
  logic lclk_r, lclk_nxt;

  always_comb begin
    slot_nxt = (slot_r == SLOT_LAST) ? 3'h0 : slot_r + 3'h1;
    lw_nxt = lw_r;
    if (newf) begin
      slot_nxt = 3'h0;
      lw_nxt = lword;
    end
    for (int k = 0; k < LANES; k++) begin
      lane_nxt[k] = vld_r & lw_r[k*SLOTS + int'(slot_r)];
    end
    lclk_nxt = vld_r & CLK_PAT[slot_r];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_r) begin
      slot_r <= 3'h0;
      lw_r <= '0;
      lane_r <= '0;
      lclk_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      lw_r <= lw_nxt;
      lane_r <= lane_nxt;
      lclk_r <= lclk_nxt;
    end
  end

  // ==================================================
  // status, audio, interrupt, i2c bridge
  logic lock_r, lock_nxt, aud_r, aud_nxt, int_r, int_nxt;
  logic sdaoe_r, sdaoe_nxt, scloe_r, scloe_nxt;

  always_comb begin
    lock_nxt = vld_r;
    aud_nxt = vld_r & aud;
    int_nxt = ~vld_r | r_int_n;
    // remote master pulls local lines low only, wired-and
    sdaoe_nxt = vld_r & ~r_sda;
    scloe_nxt = vld_r & ~r_scl;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_r) begin
      lock_r <= 1'b0;
      aud_r <= 1'b0;
      int_r <= 1'b1;
      sdaoe_r <= 1'b0;
      scloe_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      aud_r <= aud_nxt;
      int_r <= int_nxt;
      sdaoe_r <= sdaoe_nxt;
      scloe_r <= scloe_nxt;
    end
  end

  // ==================================================
  // back channel transmitter at ten megabit
  function automatic logic [3:0] crc4(input logic [5:0] d);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 6; i++) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
    end
    return c;
  endfunction

  logic [3:0] bt_r, bt_nxt, bi_r, bi_nxt;
  logic [BC_LEN-1:0] bsr_r, bsr_nxt;
  logic [5:0] bdat;
  logic btx_r, btx_nxt;

  always_comb begin
    // local bus state always goes back, even in backward mode
    bdat = {bk_r ? 4'h0 : gpio_s, scl_s, sda_s};
    bt_nxt = bt_r + 4'h1;
    bi_nxt = bi_r;
    bsr_nxt = bsr_r;
    btx_nxt = btx_r;
    if (bt_r == BC_CYC_LAST) begin
      bt_nxt = 4'h0;
      btx_nxt = bsr_r[0];
      bsr_nxt = {1'b0, bsr_r[BC_LEN-1:1]};
      if (bi_r == BC_BIT_LAST) begin
        bi_nxt = 4'h0;
        // start, data, crc, stop; sent lsb first
        bsr_nxt = {1'b0, crc4(bdat), bdat, 1'b1};
      end else begin
        bi_nxt = bi_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_r) begin
      bt_r <= 4'h0;
      bi_r <= BC_BIT_LAST;
      bsr_r <= '0;
      btx_r <= 1'b0;
    end else begin
      bt_r <= bt_nxt;
      bi_r <= bi_nxt;
      bsr_r <= bsr_nxt;
      btx_r <= btx_nxt;
    end
  end

  // ==================================================
  // output wiring, all from flip-flops
  logic zero_r;

  always_ff @(posedge mclk_i) begin
    zero_r <= 1'b0;
  end

  assign lane_o = lane_r;
  assign lane_clk_o = lclk_r;
  assign lock_o = lock_r;
  assign i2s_data_o = aud_r;
  assign interrupt_out_n_o = int_r;
  assign bc_tx_o = btx_r;
  assign sda_o = zero_r;
  assign scl_o = zero_r;
  assign sda_oe_o = sdaoe_r;
  assign scl_oe_o = scloe_r;
endmodule
`default_nettype wire

/* sdl_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// bench of the deserializer core against a serializer model
module sdl_core_bench import sdl_pkg::*;;
  logic mclk, lclk, rstn, pdn, lf, bpin, bctl, sbk, bad, rx;
  logic [3:0] lane;
  logic lnclk, lock, i2s, intn, bc, scl, scl_oe, sda, sda_oe;
  int mismatches = 0;
  int num_checks = 0;
  // far side and design; i2c wires pulled up
  sdl_ser_model sdl_ser_model_i (.link_clk_i(lclk), .bkwd_i(sbk), .lf_i(lf), .bad_i(bad),
    .rx_bit_o(rx));
  sdl_core sdl_core_i (.mclk_i(mclk), .resetn_i(rstn), .link_clk_i(lclk), .rx_bit_i(rx),
    .power_down_n_i(pdn), .low_freq_select_i(lf), .bkwd_pin_i(bpin), .bkwd_ctrl_i(bctl),
    .gpio_i(4'h5), .scl_i(!scl_oe), .scl_o(scl), .scl_oe_o(scl_oe), .sda_i(!sda_oe),
    .sda_o(sda), .sda_oe_o(sda_oe), .lane_o(lane), .lane_clk_o(lnclk), .lock_o(lock),
    .i2s_data_o(i2s), .interrupt_out_n_o(intn), .bc_tx_o(bc));
  // clocks, phases unrelated
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #15 lclk = ~lclk;
  end
  // compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset; power-down held long enough for the link side
  task automatic restart(input logic lf_v, input logic ctl_v, input logic pin_v);
    rstn <= 1'b0;
    pdn <= 1'b0; // straps change only under power-down
    lf <= lf_v;
    bctl <= ctl_v;
    bpin <= pin_v;
    sbk <= ctl_v | pin_v;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (26) @(posedge mclk);
    pdn <= 1'b1;
    @(negedge mclk);
    check({lock, intn, 2'h0}, 4'h4);
    @(posedge mclk);
  endtask
  // bounded wait for a lock level
  task automatic wait_lock(input logic lv, input int lim);
    int n;
    n = 0;
    @(negedge mclk);
    while (lock !== lv && n < lim) begin
      @(negedge mclk);
      n++;
    end
    check({3'h0, lock}, {3'h0, lv});
    @(posedge mclk);
  endtask
  // plain frames lock untrained; a broken boundary drops lock
  task automatic t_normal;
    restart(1'b0, 1'b0, 1'b0);
    wait_lock(1'b1, 12000);
    bad <= 1'b1;
    repeat (140) @(posedge mclk);
    bad <= 1'b0;
    wait_lock(1'b0, 400);
    wait_lock(1'b1, 12000);
  endtask
  // first back channel frame after reset: start, idle i2c, no gpio, crc, stop
  task automatic bc_frame;
    logic [11:0] w;
    int n;
    w = '0;
    n = 0;
    @(negedge mclk);
    while (bc !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    for (int b = 0; b < BC_LEN; b++) begin
      w[b] = bc;
      repeat (BC_BIT_CYC) @(negedge mclk);
    end
    check(w[3:0], 4'h7);
    check(w[7:4], 4'h8);
    check(w[11:8], 4'h7);
    @(posedge mclk);
  endtask
  // legacy frames by control bit, then by pin
  task automatic t_bkwd;
    for (int i = 0; i < 2; i++) begin
      restart(1'b0, i == 0, i == 1);
      bc_frame();
      wait_lock(1'b1, 12000);
      repeat (20) @(negedge mclk);
      check(lane, 4'h0);
      check({intn, i2s, scl_oe, sda_oe}, 4'h8);
      @(posedge mclk);
    end
  endtask
  // low-frequency select, each bit sent four times
  task automatic t_lowfreq;
    restart(1'b1, 1'b0, 1'b0);
    wait_lock(1'b1, 40000);
  endtask
  initial begin
    rstn = 1'b0;
    pdn = 1'b0;
    lf = 1'b0;
    bpin = 1'b0;
    bctl = 1'b0;
    sbk = 1'b0;
    bad = 1'b0;
    @(posedge mclk);
    t_normal();
    t_bkwd();
    t_lowfreq();
    final_report();
  end
  // watchdog past the longest lock searches
  initial begin
    repeat (95000) @(posedge mclk);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire

/* sdl_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// port checks of the deserializer core
module sdl_core_monitor import sdl_pkg::*; (
  // clock, reset, mode
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic bkwd_ctrl_i,
  // outputs watched
  input wire logic [LANES-1:0] lane_o,
  input wire logic lane_clk_o,
  input wire logic lock_o,
  input wire logic i2s_data_o,
  input wire logic interrupt_out_n_o,
  input wire logic bc_tx_o,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // lane clock highs last two slots at least, lows last three slots at most
  clk_pair_a: assert property ($rose(lane_clk_o) |=> lane_clk_o)
    else $error("lane clock high one slot");
  clk_gap_a: assert property (
    lock_o && $fell(lane_clk_o) |-> ##[1:3] (lane_clk_o || !lock_o))
    else $error("lane clock low too long");
  // lock comes with a delivered frame
  lock_rise_a: assert property ($rose(lock_o) |-> lane_clk_o || $past(lane_clk_o))
    else $error("lock without frame");
  reset_quiet_a: assert property (
    $rose(resetn_i) |-> !lock_o && interrupt_out_n_o && lane_o == 4'h0)
    else $error("outputs active in reset");
  // i2c drive and interrupt idle while unlocked
  oe_unlocked_a: assert property (
    !lock_o [*4] |-> !$past(scl_oe_o, 2) && !$past(sda_oe_o, 2))
    else $error("i2c driven while unlocked");
  int_unlocked_a: assert property (!lock_o [*4] |-> $past(interrupt_out_n_o, 2))
    else $error("interrupt while unlocked");
  // legacy mode silences remote features
  bkwd_quiet_a: assert property (
    bkwd_ctrl_i [*4] |-> interrupt_out_n_o && !i2s_data_o && !scl_oe_o && !sda_oe_o)
    else $error("legacy mode output active");
  // back channel bit lasts twelve cycles
  bc_bit_a: assert property ($rose(bc_tx_o) |=> bc_tx_o [*8] ##3 bc_tx_o)
    else $error("back channel bit short");
endmodule
bind sdl_core sdl_core_monitor sdl_core_monitor_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .bkwd_ctrl_i(bkwd_ctrl_i), .lane_o(lane_o), .lane_clk_o(lane_clk_o), .lock_o(lock_o),
  .i2s_data_o(i2s_data_o), .interrupt_out_n_o(interrupt_out_n_o), .bc_tx_o(bc_tx_o),
  .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

/* sdl_link_rx.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// link clock side: boundary hunt, lock, descramble
module sdl_link_rx import sdl_pkg::*; (
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic lrst_n_i,
  // serial input and modes
  input wire logic rx_bit_i,
  input wire logic bkwd_i,
  input wire logic lf_i,
  // recovered words
  output logic [PAY_W-1:0] word_o,
  output logic tog_o,
  output logic lock_o
);
  logic [1:0] rxq_r, rxq_nxt, div_r, div_nxt;
  logic [FRM_W-1:0] sr_r, sr_nxt, sr_n, fr;
  logic [5:0] cnt_r, cnt_nxt, last;
  logic [3:0] gcnt_r, gcnt_nxt;
  logic lk_r, lk_nxt, tog_r, tog_nxt, take, good;
  logic [PAY_W-1:0] lfsr_r, lfsr_nxt, word_r, word_nxt, pay;

  // ==================================================
  // next state
  always_comb begin
    rxq_nxt = {rxq_r[0], rx_bit_i};
    div_nxt = div_r + 2'h1;
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    gcnt_nxt = gcnt_r;
    lk_nxt = lk_r;
    lfsr_nxt = lfsr_r;
    word_nxt = word_r;
    tog_nxt = tog_r;
    // low frequency mode repeats each bit four times
    take = lf_i ? (div_r == LF_LAST) : 1'b1;
    sr_n = {rxq_r[1], sr_r[FRM_W-1:1]};
    fr = bkwd_i ? (sr_n >> (FRM_W - BKWD_W)) : sr_n;
    last = bkwd_i ? LAST_BKWD : LAST_FRM;
    // embedded clock bits: high one first, low one last
    good = fr[F_C1] & ~fr[last];
    // undo dc balance, then scrambling in normal frames; legacy frames are masked
    pay = fr[F_PAY +: PAY_W] ^ {PAY_W{fr[F_BAL]}};
    pay = bkwd_i ? (pay & BKWD_MASK) : (pay ^ lfsr_r);
    if (take) begin
      sr_nxt = sr_n;
      if (cnt_r >= last) begin
        if (good) begin
          cnt_nxt = 6'h00;
          lfsr_nxt = {lfsr_r[PAY_W-2:0], 1'b0} ^ (lfsr_r[PAY_W-1] ? LFSR_POLY : '0);
          // lock only after a run of valid frames
          if (gcnt_r == LOCK_FRAMES - 4'h1) begin
            lk_nxt = 1'b1;
          end else begin
            gcnt_nxt = gcnt_r + 4'h1;
          end
          if (lk_r) begin
            word_nxt = pay;
            tog_nxt = ~tog_r;
          end
        end else begin
          // slip one bit and hunt again, whatever the data
          gcnt_nxt = 4'h0;
          lk_nxt = 1'b0;
          lfsr_nxt = LFSR_SEED;
        end
      end else begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
  end

  // registers
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n_i) begin
      rxq_r <= 2'h0;
      div_r <= 2'h0;
      sr_r <= '0;
      cnt_r <= 6'h00;
      gcnt_r <= 4'h0;
      lk_r <= 1'b0;
      lfsr_r <= LFSR_SEED;
      word_r <= '0;
      tog_r <= 1'b0;
    end else begin
      rxq_r <= rxq_nxt;
      div_r <= div_nxt;
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      gcnt_r <= gcnt_nxt;
      lk_r <= lk_nxt;
      lfsr_r <= lfsr_nxt;
      word_r <= word_nxt;
      tog_r <= tog_nxt;
    end
  end

  assign word_o = word_r;
  assign tog_o = tog_r;
  assign lock_o = lk_r;
endmodule
`default_nettype wire

/* sdl_pkg.sv */
// ==================================================
// shared constants of the link deserializer
package sdl_pkg;
  // frame geometry
  localparam int FRM_W = 35;
  localparam int BKWD_W = 28;
  localparam int PAY_W = 32;
  localparam logic [5:0] LAST_FRM = 6'h22;
  localparam logic [5:0] LAST_BKWD = 6'h1B;
  localparam int F_C1 = 0;
  localparam int F_BAL = 1;
  localparam int F_PAY = 2;
  localparam logic [PAY_W-1:0] BKWD_MASK = 32'h01FF_FFFF;
  // payload field positions, normal frame
  localparam int P_RGB = 0;
  localparam int P_HS = 24;
  localparam int P_VS = 25;
  localparam int P_DE = 26;
  localparam int P_SDA = 27;
  localparam int P_SCL = 28;
  localparam int P_AUD = 29;
  localparam int P_INT = 30;
  // payload field positions, backward frame
  localparam int BK_RGB_W = 22;
  localparam int BK_HS = 22;
  localparam int BK_VS = 23;
  localparam int BK_DE = 24;
  // descrambler
  localparam logic [PAY_W-1:0] LFSR_SEED = 32'h1D87_2B41;
  localparam logic [PAY_W-1:0] LFSR_POLY = 32'h04C1_1DB7;
  // acquisition
  localparam logic [1:0] LF_LAST = 2'h3;
  localparam logic [3:0] LOCK_FRAMES = 4'h8;
  // lvds output
  localparam int LANES = 4;
  localparam int SLOTS = 7;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam logic [SLOTS-1:0] CLK_PAT = 7'h63;
  // back channel timing and framing
  localparam int MCLK_NS = 8;
  localparam int BC_BIT_NS = 100;
  localparam int BC_BIT_CYC = BC_BIT_NS / MCLK_NS;
  localparam logic [3:0] BC_CYC_LAST = 4'(BC_BIT_CYC - 1);
  localparam int BC_LEN = 12;
  localparam logic [3:0] BC_BIT_LAST = 4'hB;
endpackage

/* sdl_ser_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// serializer stand-in: framed, scrambled bit stream
module sdl_ser_model import sdl_pkg::*; (
  // link clock
  input wire logic link_clk_i,
  // modes and fault injection
  input wire logic bkwd_i,
  input wire logic lf_i,
  input wire logic bad_i,
  // serial line
  output logic rx_bit_o
);
  logic [FRM_W-1:0] frm_r = '0;
  logic [PAY_W-1:0] lfsr_r = LFSR_SEED;
  logic [5:0] idx_r = '0;
  logic [1:0] rep_r = '0;
  // bit stepping, four link clocks a bit in low-frequency mode
  always @(posedge link_clk_i) begin
    rep_r <= lf_i ? rep_r + 2'h1 : 2'h0;
    if (!lf_i || rep_r == LF_LAST) begin
      idx_r <= idx_r + 6'h01;
      // a change to legacy mode in mid-frame still wraps at the shorter length
      if (idx_r >= (bkwd_i ? LAST_BKWD : LAST_FRM)) begin
        idx_r <= 6'h00;
        lfsr_r <= {lfsr_r[30:0], 1'b0} ^ (lfsr_r[31] ? LFSR_POLY : 32'h0000_0000);
        // zero payload: scrambled in normal frames, plain in legacy
        frm_r <= bkwd_i ? {{(FRM_W-1){1'b0}}, !bad_i} : {1'b0, lfsr_r, 1'b0, !bad_i};
      end
    end
  end
  assign rx_bit_o = frm_r[idx_r];
endmodule
`default_nettype wire

/* sdl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// two flip-flop level synchroniser
module sdl_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
    q_o <= meta_r;
  end
endmodule
`default_nettype wire
